// ===== design/fsq_array_if.sv
/*
 Link between the sequencer and the flash array model.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface fsq_array_if;
    import fsq_pkg::*;
    logic we;
    logic wuid;
    logic [11:0] waddr;
    fsq_word_t wdata;
    logic ruid;
    logic [11:0] raddr;
    fsq_word_t rdata;
    modport seq (output we, output wuid, output waddr, output wdata, output ruid, output raddr, input rdata);
    modport mem (input we, input wuid, input waddr, input wdata, input ruid, input raddr, output rdata);
endinterface
`default_nettype wire

// ===== design/fsq_defs.svh
/*
 Constants of the flash row write/erase sequencer: register selects,
 control bit positions, key values, address windows, row geometry.
 Assumes it is included by bare name from the sequencer files.
*/
// Notes on behaviour
// - Latch load, row program and row erase start only right after a full unlock.
// - Any other access inside the unlock sequence cancels the pending operation.
// - Latch-only set: unlock copies the data pair into the addressed latch only.
// - Latch-only clear: unlock loads the last latch, then programs the whole row.
// - Upper address bits pick the row, lowest five bits pick the latch.
// - A row program writes only inside its own row, never a neighbour.
// - All latches return to 3FFFh when every program or erase finishes.
// - Unloaded latches stay blank, so only loaded words change the row.
// - One program writes at most 32 words, one per latch.
// - Programming never erases first; software erases target words beforehand.
// - Erase works on one whole row per operation, chosen by the row bits.
// - Erase-select set: unlock performs a row erase instead of load or program.
// - Region 0 maps 0000h-0FFFh; region 1 maps user IDs, ID words, info area.
// - The processor stalls from write-start until program or erase finishes.
// - A write-protected or illegal target clears write-start and skips the operation.
// - Erase completion sets the done flag; interrupt when its enable is set.
// - Erase leaves cells at 1; programming only pulls chosen cells to 0.
`ifndef FSQ_DEFS_SVH
`define FSQ_DEFS_SVH
`define FSQ_SEL_CTRL 3'h0
`define FSQ_SEL_KEY 3'h1
`define FSQ_SEL_ADRL 3'h2
`define FSQ_SEL_ADRH 3'h3
`define FSQ_SEL_DATL 3'h4
`define FSQ_SEL_DATH 3'h5
`define FSQ_CTRL_WR 0
`define FSQ_CTRL_PROGRAM_WRITE_ENABLE 2
`define FSQ_CTRL_ERASE 4
`define FSQ_CTRL_LATCH_ONLY_LOAD 5
`define FSQ_CTRL_REGION 6
`define FSQ_KEY_1 8'h55
`define FSQ_KEY_2 8'haa
`define FSQ_BLANK 14'h3fff
`define FSQ_LAST_IDX 5'h1f
`define FSQ_ROW_WORDS 6'h20
`define FSQ_UID_WORDS 5'h04
`define FSQ_PFM_LAST 15'h0fff
`define FSQ_UID_LAST 15'h0003
`define FSQ_ID_FIRST 15'h0005
`define FSQ_ID_LAST 15'h0006
`define FSQ_DIA_FIRST 15'h0100
`define FSQ_DIA_LAST 15'h02ff
`endif

// ===== design/fsq_flash_array.sv
/*
 Program flash words plus the user ID words, one write port and one
 combinational read port. Assumes the sequencer does the row stepping;
 contents are undefined until a row has been erased.
*/
`timescale 1ns/10ps
`default_nettype none
module fsq_flash_array
    import fsq_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Sequencer side
    fsq_array_if.mem port
);
    fsq_word_t program_flash [4096];
    fsq_word_t uid [4];

    // No reset: a real flash keeps its cells across reset
    always_ff @(posedge i_clk) begin
        if (port.we) begin
            if (port.wuid) begin
                uid[port.waddr[1:0]] <= port.wdata;
            end else begin
                program_flash[port.waddr] <= port.wdata;
            end
        end
    end

    // Read port
    assign port.rdata = port.ruid ? uid[port.raddr[1:0]] : program_flash[port.raddr];
endmodule
`default_nettype wire

// ===== design/fsq_pkg.sv
/*
 Types shared by the sequencer, its array and their link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fsq_pkg;
    typedef logic [13:0] fsq_word_t;
    typedef enum {FSQ_OP_IDLE, FSQ_OP_ERASE, FSQ_OP_PROG} fsq_op_e;
    typedef enum {FSQ_UL_IDLE, FSQ_UL_FIRST, FSQ_UL_SECOND} fsq_unlock_e;
endpackage

// ===== design/fsq_sequencer.sv
/*
 Flash row write/erase sequencer: key unlock, 32 write latches, row
 program and row erase, processor stall and done flag.
 Assumes the CPU gives one-cycle write and read strobes on i_clk and
 honours o_stall by issuing no access while it is high.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsq_defs.svh"
module fsq_sequencer
    import fsq_pkg::*;
#(
    parameter fsq_word_t REV_ID_WORD = 14'h0123, // Arbitrary value
    parameter fsq_word_t DEV_ID_WORD = 14'h0456 // Arbitrary value
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // CPU register access
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_sel,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_req,
    // System controls
    input wire logic i_write_protect,
    input wire logic i_done_irq_enable,
    input wire logic i_done_flag_clr,
    // Register views
    output logic [7:0] o_nvm_control_reg,
    output logic [7:0] o_flash_addr_high,
    output logic [7:0] o_flash_addr_low,
    output logic [7:0] o_flash_data_high,
    output logic [7:0] o_flash_data_low,
    // Status
    output logic o_stall,
    output logic o_nvm_done_flag,
    output logic o_done_irq,
    output logic o_refused
);
    fsq_array_if arr ();

    fsq_op_e state;
    fsq_unlock_e ul_state;
    fsq_unlock_e next_ul_state;
    logic wr_start;
    logic program_write_enable;
    logic erase_select;
    logic latch_only_load;
    logic config_region_select;
    logic [6:0] adr_h;
    logic [7:0] adr_l;
    logic [5:0] dat_h;
    logic [7:0] dat_l;
    logic [6:0] op_row;
    logic op_region;
    logic [4:0] word_idx;
    fsq_word_t latch [32];
    logic busy;
    logic finish;
    logic any_access;
    logic ctrl_wr;
    logic key_wr;
    logic go;
    logic allowed;
    logic do_erase;
    logic do_latch;
    logic do_prog;
    logic latch_load;
    logic [4:0] load_idx;
    fsq_word_t load_data;
    logic [14:0] cur_addr;
    fsq_word_t rd_word;
    logic all_blank;
    logic [5:0] busy_cnt;

    // Target legal for a write or erase in the given region
    function automatic logic can_write(input logic region, input logic [14:0] addr);
        return region ? (addr <= `FSQ_UID_LAST) : (addr <= `FSQ_PFM_LAST);
    endfunction

    // Target legal for a read in the given region
    function automatic logic can_read(input logic region, input logic [14:0] addr);
        logic ids;
        logic info;
        ids = (addr >= `FSQ_ID_FIRST) && (addr <= `FSQ_ID_LAST);
        info = (addr >= `FSQ_DIA_FIRST) && (addr <= `FSQ_DIA_LAST);
        return region ? (can_write(region, addr) || ids || info) : can_write(region, addr);
    endfunction

    // Access decode; accesses during a stall are ignored
    assign busy = (state != FSQ_OP_IDLE);
    assign any_access = (i_wr_en || i_rd_req) && !busy;
    assign ctrl_wr = i_wr_en && !busy && (i_wr_sel == `FSQ_SEL_CTRL);
    assign key_wr = i_wr_en && !busy && (i_wr_sel == `FSQ_SEL_KEY);
    assign cur_addr = {adr_h, adr_l};

    // Start only on write-start right after the two keys
    assign go = ctrl_wr && i_wr_data[`FSQ_CTRL_WR] && (ul_state == FSQ_UL_SECOND);
    // Protection and region legality are judged on the bits being written
    assign allowed = i_wr_data[`FSQ_CTRL_PROGRAM_WRITE_ENABLE] && !i_write_protect
        && can_write(i_wr_data[`FSQ_CTRL_REGION], cur_addr);
    assign do_erase = go && allowed && i_wr_data[`FSQ_CTRL_ERASE];
    assign do_latch = go && allowed && !i_wr_data[`FSQ_CTRL_ERASE] && i_wr_data[`FSQ_CTRL_LATCH_ONLY_LOAD];
    assign do_prog = go && allowed && !i_wr_data[`FSQ_CTRL_ERASE] && !i_wr_data[`FSQ_CTRL_LATCH_ONLY_LOAD];
    assign latch_load = do_latch || do_prog;
    assign load_idx = adr_l[4:0];
    assign load_data = {dat_h, dat_l};
    assign finish = busy && (word_idx == `FSQ_LAST_IDX);

    // Unlock tracker: any access other than the expected one falls back
    always_comb begin
        next_ul_state = FSQ_UL_IDLE;
        case (ul_state)
            FSQ_UL_IDLE: begin
                next_ul_state = FSQ_UL_IDLE;
            end
            FSQ_UL_FIRST: begin
                if (key_wr && (i_wr_data == `FSQ_KEY_2)) begin
                    next_ul_state = FSQ_UL_SECOND;
                end
            end
            FSQ_UL_SECOND: begin
                next_ul_state = FSQ_UL_IDLE;
            end
            default: begin
                next_ul_state = FSQ_UL_IDLE;
            end
        endcase
        if (key_wr && (i_wr_data == `FSQ_KEY_1)) begin
            next_ul_state = FSQ_UL_FIRST;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ul_state <= FSQ_UL_IDLE;
        end else if (any_access) begin
            ul_state <= next_ul_state;
        end
    end

    // Control register; write-start is set only by an accepted row operation
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_start <= 1'b0;
            program_write_enable <= 1'b0;
            erase_select <= 1'b0;
            latch_only_load <= 1'b0;
            config_region_select <= 1'b0;
        end else if (ctrl_wr) begin
            wr_start <= do_erase || do_prog; // Latch load and refusal leave it clear
            program_write_enable <= i_wr_data[`FSQ_CTRL_PROGRAM_WRITE_ENABLE];
            erase_select <= i_wr_data[`FSQ_CTRL_ERASE];
            latch_only_load <= i_wr_data[`FSQ_CTRL_LATCH_ONLY_LOAD];
            config_region_select <= i_wr_data[`FSQ_CTRL_REGION];
        end else if (finish) begin
            wr_start <= 1'b0;
        end
    end

    // Address registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            adr_h <= 7'h00;
            adr_l <= 8'h00;
        end else if (i_wr_en && !busy) begin
            if (i_wr_sel == `FSQ_SEL_ADRH) begin
                adr_h <= i_wr_data[6:0];
            end
            if (i_wr_sel == `FSQ_SEL_ADRL) begin
                adr_l <= i_wr_data;
            end
        end
    end

    // Read data path; illegal read addresses return zero
    always_comb begin
        rd_word = 14'h0000;
        if (can_read(config_region_select, cur_addr)) begin
            if (!config_region_select || (cur_addr <= `FSQ_UID_LAST)) begin
                rd_word = arr.rdata;
            end else if (cur_addr == `FSQ_ID_FIRST) begin
                rd_word = REV_ID_WORD;
            end else if (cur_addr == `FSQ_ID_LAST) begin
                rd_word = DEV_ID_WORD;
            end
        end
    end

    // Data registers; a CPU write in the same cycle beats a read
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dat_h <= 6'h00;
            dat_l <= 8'h00;
        end else if (i_wr_en && !busy) begin
            if (i_wr_sel == `FSQ_SEL_DATH) begin
                dat_h <= i_wr_data[5:0];
            end
            if (i_wr_sel == `FSQ_SEL_DATL) begin
                dat_l <= i_wr_data;
            end
        end else if (i_rd_req && !busy) begin
            dat_h <= rd_word[13:8];
            dat_l <= rd_word[7:0];
        end
    end

    // Row engine: one word per cycle, row frozen at the start
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= FSQ_OP_IDLE;
            op_row <= 7'h00;
            op_region <= 1'b0;
            word_idx <= 5'h00;
        end else begin
            case (state)
                FSQ_OP_IDLE: begin
                    word_idx <= 5'h00;
                    if (do_erase || do_prog) begin
                        state <= do_erase ? FSQ_OP_ERASE : FSQ_OP_PROG;
                        op_row <= cur_addr[11:5];
                        op_region <= i_wr_data[`FSQ_CTRL_REGION];
                    end
                end
                FSQ_OP_ERASE, FSQ_OP_PROG: begin
                    word_idx <= 5'(word_idx + 5'h01);
                    if (finish) begin
                        state <= FSQ_OP_IDLE;
                    end
                end
                default: begin
                    state <= FSQ_OP_IDLE;
                end
            endcase
        end
    end

    // Array drive; the user ID region has only four words, the rest of its row is skipped
    assign arr.we = busy && (!op_region || (word_idx < `FSQ_UID_WORDS));
    assign arr.wuid = op_region;
    assign arr.waddr = {op_row, word_idx};
    // Erase writes ones; program ANDs so cells only go to zero
    assign arr.wdata = (state == FSQ_OP_ERASE) ? `FSQ_BLANK : (arr.rdata & latch[word_idx]);
    assign arr.ruid = busy ? op_region : config_region_select;
    assign arr.raddr = busy ? {op_row, word_idx} : cur_addr[11:0];

    // Write latches, blanked after every program or erase
    generate
        for (genvar g = 0; g < 32; g++) begin : g_latch
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    latch[g] <= `FSQ_BLANK;
                end else if (finish) begin
                    latch[g] <= `FSQ_BLANK;
                end else if (latch_load && (load_idx == 5'(g))) begin
                    latch[g] <= load_data;
                end
            end
        end
    endgenerate

    // Done flag: a completion in the clearing cycle still wins
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_nvm_done_flag <= 1'b0;
        end else if (finish) begin
            o_nvm_done_flag <= 1'b1;
        end else if (i_done_flag_clr) begin
            o_nvm_done_flag <= 1'b0;
        end
    end

    // Refusal pulse, one cycle after the rejected write-start
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_refused <= 1'b0;
        end else begin
            o_refused <= go && !allowed;
        end
    end

    // Outputs; stall is combinational so the CPU holds off in the first busy cycle
    assign o_stall = busy;
    assign o_done_irq = o_nvm_done_flag && i_done_irq_enable;
    assign o_nvm_control_reg = {1'b0, config_region_select, latch_only_load, erase_select,
        1'b0, program_write_enable, 1'b0, wr_start};
    assign o_flash_addr_high = {1'b0, adr_h};
    assign o_flash_addr_low = adr_l;
    assign o_flash_data_high = {2'b00, dat_h};
    assign o_flash_data_low = dat_l;

    fsq_flash_array u_array (
        .i_clk (i_clk),
        .port (arr)
    );

    // Helpers watched only by the checks below
    always_comb begin
        all_blank = 1'b1;
        for (int i = 0; i < 32; i++) begin
            all_blank = all_blank && (latch[i] == `FSQ_BLANK);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_cnt <= 6'h00;
        end else begin
            busy_cnt <= busy ? 6'(busy_cnt + 6'h01) : 6'h00;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_key_first;
        key_wr && (i_wr_data == `FSQ_KEY_1);
    endsequence

    sequence s_key_second;
        key_wr && (i_wr_data == `FSQ_KEY_2);
    endsequence

    sequence s_start;
        ctrl_wr && i_wr_data[`FSQ_CTRL_WR];
    endsequence

    a_start_needs_keys: assert property ($rose(wr_start) |-> $past(ul_state) == FSQ_UL_SECOND)
        else $error("write-start rose without unlock");
    a_broken_unlock: assert property (s_key_first ##1 !any_access ##1 (any_access && !key_wr) ##1 !any_access
        ##1 s_key_second ##1 !any_access ##1 s_start |-> !go) else $error("broken unlock still started");
    a_unlock_erase: assert property (s_key_first ##1 !any_access ##1 s_key_second ##1 !any_access
        ##1 s_start ##0 (allowed && i_wr_data[`FSQ_CTRL_ERASE]) |=> (state == FSQ_OP_ERASE) && o_stall && wr_start)
        else $error("unlock with erase select did not erase");
    a_latch_only: assert property (do_latch |=> !busy && !wr_start && latch[$past(load_idx)] == $past(load_data))
        else $error("latch-only load wrong");
    a_prog_start: assert property (do_prog |=> state == FSQ_OP_PROG ##0 latch[$past(load_idx)] == $past(load_data))
        else $error("program did not load last latch and start");
    a_row_length: assert property ($fell(busy) |-> busy_cnt == `FSQ_ROW_WORDS)
        else $error("row operation length not 32 words");
    a_row_fixed: assert property (busy && arr.we |-> arr.waddr[11:5] == op_row ##1 (!busy || $stable(op_row)))
        else $error("row write left its row");
    a_latch_blank: assert property ($fell(busy) |-> all_blank && o_nvm_done_flag && !wr_start)
        else $error("latches not blank or flag not set at end");
    a_refuse_wp: assert property (go && i_write_protect |=> !wr_start && !busy && o_refused)
        else $error("protected target not refused");
    a_erase_ones: assert property (arr.we && state == FSQ_OP_ERASE |-> arr.wdata == `FSQ_BLANK)
        else $error("erase wrote non-blank word");
    a_stall_hold: assert property (wr_start |-> o_stall)
        else $error("write-start set without stall");
    a_flag_set_wins: assert property (finish && i_done_flag_clr |=> o_nvm_done_flag)
        else $error("done flag lost to clear");
endmodule
`default_nettype wire

// ===== tb/tb_fsq_sequencer.sv
/*
 Self-checking bench of the flash row sequencer: reset values, unlock
 tracking, latch loads, row program and erase, refusals and region 1.
 Assumes the package, the link interface and the design modules are compiled
 first, and that fsq_defs.svh is on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsq_defs.svh"
module tb_fsq_sequencer
    import fsq_pkg::*;
;
    localparam fsq_word_t REV_ID = 14'h0123; // Arbitrary value
    localparam fsq_word_t DEV_ID = 14'h0456; // Arbitrary value
    logic i_clk, i_reset_n, i_wr_en, i_rd_req;
    logic [2:0] i_wr_sel;
    logic [7:0] i_wr_data;
    logic i_write_protect, i_done_irq_enable, i_done_flag_clr;
    logic [7:0] o_nvm_control_reg, o_flash_addr_high, o_flash_addr_low, o_flash_data_high, o_flash_data_low;
    logic o_stall, o_nvm_done_flag, o_done_irq, o_refused;
    int errors = 0;
    int num_checks = 0;
    int cyc;
    logic refd, ws;

    fsq_sequencer #(.REV_ID_WORD(REV_ID), .DEV_ID_WORD(DEV_ID)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel),
        .i_wr_data(i_wr_data), .i_rd_req(i_rd_req), .i_write_protect(i_write_protect),
        .i_done_irq_enable(i_done_irq_enable), .i_done_flag_clr(i_done_flag_clr),
        .o_nvm_control_reg(o_nvm_control_reg), .o_flash_addr_high(o_flash_addr_high),
        .o_flash_addr_low(o_flash_addr_low), .o_flash_data_high(o_flash_data_high),
        .o_flash_data_low(o_flash_data_low), .o_stall(o_stall), .o_nvm_done_flag(o_nvm_done_flag),
        .o_done_irq(o_done_irq), .o_refused(o_refused));

    // Free-running 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Verdict and the single exit of the run
    task automatic end_of_test();
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One register write; the idle cycle after it keeps strobes single-assigned
    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        i_wr_en = 1'b1;
        i_wr_sel = sel;
        i_wr_data = data;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic set_addr(input logic [14:0] a);
        wr(`FSQ_SEL_ADRL, a[7:0]);
        wr(`FSQ_SEL_ADRH, {1'b0, a[14:8]});
    endtask

    task automatic ld(input logic [14:0] a, input fsq_word_t w);
        set_addr(a);
        wr(`FSQ_SEL_DATL, w[7:0]);
        wr(`FSQ_SEL_DATH, {2'b00, w[13:8]});
    endtask

    // Reads one word through the data pair and compares it
    task automatic rd(input logic [14:0] a, input fsq_word_t exp, input string what);
        set_addr(a);
        i_rd_req = 1'b1;
        @(negedge i_clk);
        i_rd_req = 1'b0;
        check({2'b00, o_flash_data_high[5:0], o_flash_data_low}, {2'b00, exp}, what);
    endtask

    // Unlock then control write; mode[0] breaks the keys, mode[1] pokes while stalled
    task automatic op(input logic [7:0] ctrl, input logic [1:0] mode, output int n, output logic r,
                      output logic s);
        logic [7:0] adr;
        adr = o_flash_addr_low;
        wr(`FSQ_SEL_KEY, `FSQ_KEY_1);
        if (mode[0]) begin
            wr(`FSQ_SEL_ADRL, adr);
        end
        wr(`FSQ_SEL_KEY, `FSQ_KEY_2);
        i_wr_en = 1'b1;
        i_wr_sel = `FSQ_SEL_CTRL;
        i_wr_data = ctrl;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        r = o_refused;
        s = o_nvm_control_reg[`FSQ_CTRL_WR];
        n = 0;
        while (o_stall === 1'b1 && n < 100) begin
            if (mode[1] && n == 4) begin
                i_wr_en = 1'b1;
                i_wr_sel = `FSQ_SEL_ADRL;
                i_wr_data = ~adr;
            end
            if (mode[1] && n == 5) begin
                i_wr_en = 1'b0;
            end
            n++;
            @(negedge i_clk);
        end
        if (n >= 100) begin
            errors++;
            end_of_test();
        end
    endtask

    task automatic erase_row(input logic [14:0] a);
        set_addr(a);
        op(8'h15, 2'b00, cyc, refd, ws);
        check(16'(cyc), 16'h0020, "erase busy cycles");
    endtask

    task automatic t_reset();
        check({o_nvm_control_reg, o_flash_addr_low}, 16'h0000, "ctrl and addr after reset");
        check({o_flash_data_high, o_flash_data_low}, 16'h0000, "data after reset");
        check({13'h0000, o_stall, o_nvm_done_flag, o_refused}, 16'h0000, "status after reset");
    endtask

    // Erase with an access attempted during the stall, then the done flag path
    task automatic t_erase();
        set_addr(15'h0020);
        op(8'h15, 2'b10, cyc, refd, ws);
        check(16'(cyc), 16'h0020, "erase stall length");
        check(16'({ws, refd}), 16'h0002, "write-start up, no refusal");
        check(16'(o_nvm_control_reg), 16'h0014, "write-start cleared");
        check({o_flash_addr_high, o_flash_addr_low}, 16'h0020, "access during stall ignored");
        check(16'({o_nvm_done_flag, o_done_irq}), 16'h0002, "flag set, irq masked");
        i_done_irq_enable = 1'b1;
        @(negedge i_clk);
        check(16'(o_done_irq), 16'h0001, "irq with enable");
        i_done_flag_clr = 1'b1;
        @(negedge i_clk);
        i_done_flag_clr = 1'b0;
        check(16'({o_nvm_done_flag, o_done_irq}), 16'h0000, "flag cleared");
        rd(15'h0020, `FSQ_BLANK, "erased first word");
        rd(15'h003f, `FSQ_BLANK, "erased last word");
        erase_row(15'h0000);
        erase_row(15'h0040);
    endtask

    // Latch-only load, then final load with program of the whole row
    task automatic t_program();
        ld(15'h0023, 14'h1234);
        op(8'h25, 2'b00, cyc, refd, ws);
        check({16'(cyc)}, 16'h0000, "latch load does not stall");
        check(16'({ws, refd}), 16'h0000, "latch load no write-start");
        rd(15'h0023, `FSQ_BLANK, "latch load leaves array");
        ld(15'h003f, 14'h2a5a);
        op(8'h05, 2'b00, cyc, refd, ws);
        check(16'(cyc), 16'h0020, "program stall length");
        check(16'(o_nvm_done_flag), 16'h0001, "flag after program");
        rd(15'h0023, 14'h1234, "loaded latch programmed");
        rd(15'h003f, 14'h2a5a, "last latch programmed");
        rd(15'h0024, `FSQ_BLANK, "unloaded latch blank");
        rd(15'h0040, `FSQ_BLANK, "next row untouched");
        rd(15'h001f, `FSQ_BLANK, "previous row untouched");
    endtask

    // Erase blanks a loaded latch; programming twice only clears bits
    task automatic t_blank();
        ld(15'h0047, 14'h0f0f);
        op(8'h25, 2'b00, cyc, refd, ws);
        erase_row(15'h0040);
        ld(15'h0048, 14'h3ff0);
        op(8'h05, 2'b00, cyc, refd, ws);
        rd(15'h0047, `FSQ_BLANK, "latch blanked by erase");
        rd(15'h0048, 14'h3ff0, "programmed word");
        ld(15'h0048, 14'h0fff);
        op(8'h05, 2'b00, cyc, refd, ws);
        rd(15'h0048, 14'h0ff0, "no erase before program");
    endtask

    // Broken or missing unlock must start nothing
    task automatic t_unlock();
        ld(15'h0001, 14'h0000);
        op(8'h05, 2'b01, cyc, refd, ws);
        check({16'(cyc)}, 16'h0000, "broken unlock no stall");
        check(16'({ws, refd}), 16'h0000, "broken unlock no start");
        check(16'(o_nvm_control_reg), 16'h0004, "bits stored, start dropped");
        wr(`FSQ_SEL_CTRL, 8'h05);
        check(16'({o_stall, o_nvm_control_reg}), 16'h0004, "start without keys");
        rd(15'h0001, `FSQ_BLANK, "array unchanged");
    endtask

    task automatic t_refuse();
        ld(15'h0002, 14'h0000);
        i_write_protect = 1'b1;
        op(8'h15, 2'b00, cyc, refd, ws);
        i_write_protect = 1'b0;
        check({16'(cyc)}, 16'h0000, "protected erase skipped");
        check(16'({ws, refd}), 16'h0001, "protected erase refused");
        op(8'h01, 2'b00, cyc, refd, ws);
        check(16'({o_stall, refd, o_nvm_control_reg[0]}), 16'h0002, "program without enable");
        rd(15'h0002, `FSQ_BLANK, "refused program left array");
    endtask

    // Region 1: user IDs writable, ID words read-only
    task automatic t_region();
        set_addr(15'h0000);
        // Clear held over the whole erase: completion must still leave the flag set
        i_done_flag_clr = 1'b1;
        op(8'h55, 2'b00, cyc, refd, ws);
        i_done_flag_clr = 1'b0;
        check(16'(cyc), 16'h0020, "user ID erase");
        check(16'(o_nvm_done_flag), 16'h0001, "completion beats clear");
        ld(15'h0002, 14'h1111);
        op(8'h45, 2'b00, cyc, refd, ws);
        rd(15'h0002, 14'h1111, "user ID written");
        rd(15'h0005, REV_ID, "revision word");
        rd(15'h0006, DEV_ID, "device word");
        rd(15'h0100, 14'h0000, "info area reads zero");
        check({o_flash_addr_high, o_flash_addr_low}, 16'h0100, "address pair");
        ld(15'h0005, 14'h0000);
        op(8'h45, 2'b00, cyc, refd, ws);
        check({15'(cyc), refd}, 16'h0001, "ID word write refused");
        rd(15'h0005, REV_ID, "revision word kept");
        wr(`FSQ_SEL_CTRL, 8'h04);
        rd(15'h0002, `FSQ_BLANK, "region 0 separate");
    endtask

    // Main sequence
    initial begin
        i_reset_n = 1'b0;
        i_wr_en = 1'b0;
        i_wr_sel = 3'h0;
        i_wr_data = 8'h00;
        i_rd_req = 1'b0;
        i_write_protect = 1'b0;
        i_done_irq_enable = 1'b0;
        i_done_flag_clr = 1'b0;
        repeat (8) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        t_reset();
        t_erase();
        t_program();
        t_blank();
        t_unlock();
        t_refuse();
        t_region();
        end_of_test();
    end
endmodule
`default_nettype wire
